// ==== src/adc_serial_result_port.sv ====
`timescale 1ns/10ps
`include "serial_port_consts.svh"
module adc_serial_result_port (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     iface_sel_lo,
    input  wire logic                     iface_sel_hi,
    input  wire logic                     clock_source_sel,
    input  wire logic                     read_timing_cascade_in,
    input  wire logic                     serial_clock_divider,
    input  wire logic                     clock_invert,
    input  wire logic                     convert_start_n,
    input  wire logic [`RESULT_BITS-1:0]  conv_result,
    input  wire logic                     cs_n,
    input  wire logic                     rd_n,
    input  wire logic                     sclk_in,
    output logic                          sclk_out,
    output logic                          sclk_oe,
    output logic                          frame_sync,
    output logic                          frame_sync_oe,
    output logic                          serial_result_out,
    output logic                          serial_result_oe,
    output logic                          busy,
    output logic                          incomplete_read_flag
);
    logic                          converting;
    logic                          conv_done;
    logic                          conv_start;
    logic                          tick;

    logic [`RESULT_BITS-1:0]       shift_q;
    logic [`RESULT_BITS-1:0]       res_q;
    logic [`BIT_CNT_W-1:0]         cnt_q;
    logic                          sdo_q;
    logic                          sclk_q;
    logic                          sync_q;
    logic                          sclk_prev_q;
    logic                          casc_q;
    logic                          left_q;
    logic                          err_q;
    logic                          mbusy_q;
    serial_port_pkg::master_state_t mst_q;

    conv_timer u_conv (
        .clk             (clk),
        .rst_b           (rst_b),
        .convert_start_n (convert_start_n),
        .converting      (converting),
        .conv_done       (conv_done),
        .conv_start      (conv_start)
    );

    wire serial_en  = iface_sel_lo & iface_sel_hi;
    wire master     = serial_en & ~clock_source_sel;
    wire slave      = serial_en & clock_source_sel;
    wire rd_during  = ~read_timing_cascade_in;
    wire selected   = ~cs_n & ~rd_n;
    wire cascade_on = slave & read_timing_cascade_in;
    wire m_after    = master & read_timing_cascade_in;
    wire m_running  = (mst_q == serial_port_pkg::M_SHIFT);

    // Master starts after conversion, or at start of next one for read-during
    wire m_kick = master && (m_after ? conv_done : conv_start);

    sclk_divider u_div (
        .clk   (clk),
        .rst_b (rst_b),
        .run   (m_running),
        .slow  (serial_clock_divider),
        .tick  (tick)
    );

    // Slave shifts on the rising host edge, so the bit holds a whole period
    wire s_rise = slave && selected && sclk_in && !sclk_prev_q;
    wire s_fall = slave && selected && !sclk_in && sclk_prev_q;
    wire m_rise = m_running && tick && !sclk_q;
    wire m_fall = m_running && tick && sclk_q;
    wire last_m = m_fall && (cnt_q == `BIT_CNT_LAST);

    // Slave loads at conversion end; read-after keeps an unfinished read alive
    wire s_load    = slave && conv_done && !(!rd_during && left_q);
    wire s_missed  = slave && rd_during && conv_done && left_q;
    // Master loads only from M_IDLE, so a kick that lands while a slow frame still runs is dropped
    wire m_idle    = (mst_q == serial_port_pkg::M_IDLE);
    wire m_load    = m_kick && m_idle;
    wire [`RESULT_BITS-1:0] m_word = m_after ? conv_result : res_q;
    wire load_res  = m_load || s_load;
    wire [`RESULT_BITS-1:0] load_word = m_load ? m_word : conv_result;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            // Follows the pin so an idle-high host clock gives no false edge
            sclk_prev_q <= sclk_in;
        end else begin
            sclk_prev_q <= sclk_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mst_q  <= serial_port_pkg::M_IDLE;
            sclk_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            case (mst_q)
                serial_port_pkg::M_IDLE: begin
                    if (m_kick) begin
                        mst_q  <= serial_port_pkg::M_SHIFT;
                        sync_q <= 1'b1;
                    end
                end
                serial_port_pkg::M_SHIFT: begin
                    if (tick) begin
                        sclk_q <= ~sclk_q;
                    end
                    if (last_m) begin
                        mst_q  <= serial_port_pkg::M_DONE;
                        sync_q <= 1'b0;
                    end
                end
                serial_port_pkg::M_DONE: begin
                    mst_q <= serial_port_pkg::M_IDLE;
                end
                default: begin
                    mst_q <= serial_port_pkg::M_IDLE;
                end
            endcase
        end
    end

    // Shift register: MSB leaves first, cascade data enters at the bottom
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shift_q <= '0;
            cnt_q   <= `BIT_CNT_ZERO;
            sdo_q   <= 1'b0;
            casc_q  <= 1'b0;
            left_q  <= 1'b0;
        end else begin
            if (s_fall && cascade_on) begin
                casc_q <= read_timing_cascade_in;
            end
            if (load_res) begin
                shift_q <= load_word;
                sdo_q   <= load_word[`RESULT_BITS-1];
                cnt_q   <= `BIT_CNT_ZERO;
                left_q  <= 1'b1;
                // Upstream MSB already stands at the cascade pin
                casc_q  <= read_timing_cascade_in;
            end else if (m_fall || s_rise) begin
                shift_q <= {shift_q[`RESULT_BITS-2:0], casc_q};
                sdo_q   <= shift_q[`RESULT_BITS-2];
                if (cnt_q == `BIT_CNT_LAST) begin
                    left_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            err_q   <= 1'b0;
            mbusy_q <= 1'b0;
            res_q   <= '0;
        end else begin
            err_q <= s_missed;
            // Held copy feeds the master read-during frame of the next conversion
            if (conv_done) begin
                res_q <= conv_result;
            end
            if (m_after && conv_done) begin
                mbusy_q <= 1'b1;
            end else if (last_m || !m_after) begin
                mbusy_q <= 1'b0;
            end
        end
    end

    assign busy                 = converting | mbusy_q;
    assign incomplete_read_flag = err_q;
    assign sclk_out             = sclk_q ^ clock_invert;
    assign frame_sync           = sync_q ^ clock_invert;
    assign sclk_oe              = master & selected;
    assign frame_sync_oe        = master & selected;
    assign serial_result_out    = sdo_q;
    assign serial_result_oe     = serial_en & selected;

    sequence s_shift_busy;
        mbusy_q [*2];
    endsequence
    property p_busy_ext;
        @(posedge clk) disable iff (!rst_b)
        (m_after && conv_done && !m_running) |=> s_shift_busy;
    endproperty
    a_busy_ext: assert property (p_busy_ext) else $error("busy not extended");

    property p_err_pulse;
        @(posedge clk) disable iff (!rst_b)
        s_missed |=> incomplete_read_flag ##1 !incomplete_read_flag;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("read error not pulsed");

    property p_float;
        @(posedge clk) disable iff (!rst_b)
        (cs_n || rd_n) |-> !serial_result_oe && !sclk_oe;
    endproperty
    a_float: assert property (p_float) else $error("outputs driven while deselected");

    property p_mode_gate;
        @(posedge clk) disable iff (!rst_b)
        !(iface_sel_lo && iface_sel_hi) |-> !serial_result_oe;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("serial driven in parallel mode");

    property p_slave_hold;
        @(posedge clk) disable iff (!rst_b)
        (slave && !selected && !load_res) |=> $stable(sdo_q);
    endproperty
    a_slave_hold: assert property (p_slave_hold) else $error("shift without select");

    property p_msb_first;
        @(posedge clk) disable iff (!rst_b)
        (s_load || (m_load && m_after)) |=> sdo_q == $past(conv_result[`RESULT_BITS-1]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit is not MSB");

    property p_msb_during;
        @(posedge clk) disable iff (!rst_b)
        (m_load && !m_after) |=> sdo_q == $past(res_q[`RESULT_BITS-1]);
    endproperty
    a_msb_during: assert property (p_msb_during) else $error("older result not sent");

    property p_sync_master;
        @(posedge clk) disable iff (!rst_b)
        m_load |=> m_running && sync_q;
    endproperty
    a_sync_master: assert property (p_sync_master) else $error("frame strobe missing");

    property p_busy_rise;
        @(posedge clk) disable iff (!rst_b)
        conv_start |=> busy;
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");

    // First rising edge of the generated clock, per divider setting
    sequence s_first_rise_fast;
        !sclk_q ##2 sclk_q;
    endsequence
    sequence s_first_rise_slow;
        !sclk_q [*8] ##1 sclk_q;
    endsequence

    property p_div_fast;
        @(posedge clk) disable iff (!rst_b)
        (m_load && !serial_clock_divider) |=> s_first_rise_fast;
    endproperty
    a_div_fast: assert property (p_div_fast) else $error("fast clock mistimed");

    property p_div_slow;
        @(posedge clk) disable iff (!rst_b)
        (m_load && serial_clock_divider) |=> s_first_rise_slow;
    endproperty
    a_div_slow: assert property (p_div_slow) else $error("slow clock mistimed");

    property p_sdo_hold_rise;
        @(posedge clk) disable iff (!rst_b)
        m_rise |=> $stable(sdo_q);
    endproperty
    a_sdo_hold_rise: assert property (p_sdo_hold_rise) else $error("data moved on rise");

    property p_invert;
        @(posedge clk) disable iff (!rst_b)
        clock_invert |-> (sclk_out != sclk_q) && (frame_sync != sync_q);
    endproperty
    a_invert: assert property (p_invert) else $error("polarity not inverted");

    property p_after_no_kick;
        @(posedge clk) disable iff (!rst_b)
        (m_after && m_idle && conv_start) |=> m_idle;
    endproperty
    a_after_no_kick: assert property (p_after_no_kick) else $error("frame began at start");

    property p_frame_end;
        @(posedge clk) disable iff (!rst_b)
        last_m |=> !m_running && !sync_q;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame not closed");

    property p_busy_drop;
        @(posedge clk) disable iff (!rst_b)
        (m_after && last_m && !conv_done) |=> !mbusy_q;
    endproperty
    a_busy_drop: assert property (p_busy_drop) else $error("busy held after frame");

    property p_slave_shift;
        @(posedge clk) disable iff (!rst_b)
        (s_rise && !load_res) |=> sdo_q == $past(shift_q[`RESULT_BITS-2]);
    endproperty
    a_slave_shift: assert property (p_slave_shift) else $error("slave bit wrong");

    property p_casc_idle;
        @(posedge clk) disable iff (!rst_b)
        (!cascade_on && !load_res) |=> $stable(casc_q);
    endproperty
    a_casc_idle: assert property (p_casc_idle) else $error("cascade taken off mode");

    property p_casc_take;
        @(posedge clk) disable iff (!rst_b)
        (s_fall && cascade_on && !load_res) |=> casc_q == $past(read_timing_cascade_in);
    endproperty
    a_casc_take: assert property (p_casc_take) else $error("cascade bit not taken");

    property p_no_false_err;
        @(posedge clk) disable iff (!rst_b)
        (conv_done && !left_q) |=> !incomplete_read_flag;
    endproperty
    a_no_false_err: assert property (p_no_false_err) else $error("error after full read");

    property p_keep_partial;
        @(posedge clk) disable iff (!rst_b)
        (slave && !rd_during && conv_done && left_q && !s_rise) |=> left_q && $stable(shift_q);
    endproperty
    a_keep_partial: assert property (p_keep_partial) else $error("partial read lost");
endmodule

// ==== inc/serial_port_consts.svh ====
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
`define RESULT_BITS      18
`define BIT_CNT_W        5
`define BIT_CNT_LAST     5'h11
`define BIT_CNT_ZERO     5'h00
`define CONV_CYCLES      8'h7C
`define CONV_HALF        8'h3E
`define CONV_CNT_W       8
`define DIV_FAST         4'h1
`define DIV_SLOW         4'h7
`endif

// ==== inc/serial_port_pkg.sv ====
package serial_port_pkg;
    typedef enum logic [1:0] {
        M_IDLE,
        M_SHIFT,
        M_DONE
    } master_state_t;
endpackage

// ==== src/conv_timer.sv ====
`timescale 1ns/10ps
`include "serial_port_consts.svh"
module conv_timer (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     convert_start_n,
    output logic                          converting,
    output logic                          conv_done,
    output logic                          conv_start
);
    logic                      cnv_q;
    logic [`CONV_CNT_W-1:0]    cnt_q;
    logic                      run_q;
    wire                       fall = cnv_q & ~convert_start_n;

    // Starts while running are ignored
    assign conv_start = fall & ~run_q;
    assign conv_done  = run_q && (cnt_q == `CONV_CYCLES);
    assign converting = run_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnv_q <= 1'b1;
            cnt_q <= '0;
            run_q <= 1'b0;
        end else begin
            cnv_q <= convert_start_n;
            if (conv_start) begin
                run_q <= 1'b1;
                cnt_q <= '0;
            end else if (conv_done) begin
                run_q <= 1'b0;
            end else if (run_q) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    property p_conv_len;
        @(posedge clk) disable iff (!rst_b)
        conv_start |=> run_q [*8] ##1 run_q;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion aborted early");
endmodule

// ==== src/sclk_divider.sv ====
`timescale 1ns/10ps
`include "serial_port_consts.svh"
module sclk_divider (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       run,
    input  wire logic       slow,
    output logic            tick
);
    logic [3:0] cnt_q;
    wire  [3:0] limit = slow ? `DIV_SLOW : `DIV_FAST;

    assign tick = run && (cnt_q == limit);

    always_ff @(posedge clk) begin
        if (!rst_b || !run || tick) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    property p_tick_space;
        @(posedge clk) disable iff (!rst_b)
        tick |=> !tick;
    endproperty
    a_tick_space: assert property (p_tick_space) else $error("divider ticks back to back");
endmodule

// ==== dv/host_serial_model.sv ====
`timescale 1ns/10ps
module host_serial_model (
    input  wire logic clk,
    input  wire logic sdo,
    output logic      cs_n,
    output logic      rd_n,
    output logic      sclk
);
    logic [31:0] got;

    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        sclk = 1'b0;
        got  = 32'h0000_0000;
    end

    task automatic select(input logic on);
        cs_n <= ~on;
        rd_n <= ~on;
        @(negedge clk);
    endtask

    // Burst clock idles low; 3-clk levels leave margin over the 1-clk sampling need
    task automatic shift(input int n, input logic on, input logic keep);
        select(on);
        for (int i = 0; i < n; i++) begin
            got = {got[30:0], sdo};
            sclk <= 1'b1;
            repeat (3) @(negedge clk);
            sclk <= 1'b0;
            repeat (3) @(negedge clk);
        end
        if (!keep) begin
            select(1'b0);
        end
    endtask
endmodule

// ==== dv/adc_serial_result_port_tb.sv ====
`timescale 1ns/10ps
`include "serial_port_consts.svh"
module adc_serial_result_port_tb;
    logic                    clk = 1'b0;
    logic                    rst_b = 1'b0;
    logic                    iface_sel_lo = 1'b1;
    logic                    iface_sel_hi = 1'b1;
    logic                    clock_source_sel = 1'b1;
    logic                    read_timing_cascade_in = 1'b1;
    logic                    serial_clock_divider = 1'b0;
    logic                    clock_invert = 1'b0;
    logic                    convert_start_n = 1'b1;
    logic [`RESULT_BITS-1:0] conv_result = 18'h2D35A;
    logic                    cs_n, rd_n, sclk_in, sclk_out, sclk_oe, frame_sync;
    logic                    serial_result_out, serial_result_oe, busy, rd_err;
    logic                    frame_sync_oe;
    logic [31:0]             mword = 32'h0000_0000;
    logic                    s_q = 1'b0;
    logic                    busy_at = 1'b0;
    int                      failures = 0;
    int                      n_compared = 0;
    int                      cyc = 0;
    int                      last = 0;
    int                      gap = 0;
    int                      mcnt = 0;
    int                      nerr = 0;
    int                      t0;
    int                      e0;

    always #5 clk = ~clk;

    adc_serial_result_port u_adc_serial_result_port (
        .clk(clk), .rst_b(rst_b), .iface_sel_lo(iface_sel_lo), .iface_sel_hi(iface_sel_hi),
        .clock_source_sel(clock_source_sel), .read_timing_cascade_in(read_timing_cascade_in),
        .serial_clock_divider(serial_clock_divider), .clock_invert(clock_invert),
        .convert_start_n(convert_start_n), .conv_result(conv_result), .cs_n(cs_n),
        .rd_n(rd_n), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .frame_sync(frame_sync), .frame_sync_oe(frame_sync_oe),
        .serial_result_out(serial_result_out),
        .serial_result_oe(serial_result_oe), .busy(busy), .incomplete_read_flag(rd_err));

    host_serial_model u_host_serial_model (
        .clk(clk), .sdo(serial_result_out), .cs_n(cs_n), .rd_n(rd_n), .sclk(sclk_in));

    // Master receiver: sample on the edge where data is steady, per polarity
    always @(negedge clk) begin
        cyc <= cyc + 1;
        s_q <= sclk_out ^ clock_invert;
        if (rd_err === 1'b1) nerr <= nerr + 1;
        if (sclk_oe === 1'b1 && (frame_sync ^ clock_invert) === 1'b1
            && (sclk_out ^ clock_invert) === 1'b1 && s_q === 1'b0) begin
            mword <= {mword[30:0], serial_result_out};
            mcnt <= mcnt + 1;
            gap <= cyc - last;
            last <= cyc;
            busy_at <= busy;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic convert();
        convert_start_n <= 1'b0;
        @(negedge clk);
        convert_start_n <= 1'b1;
        @(negedge clk);
    endtask

    // Bounded wait; a long master read-after frame can hold busy past 400 clk
    task automatic wait_idle();
        for (int k = 0; k < 600 && busy !== 1'b0; k++) @(negedge clk);
        chk("idle_wait", 0, busy);
    endtask

    task automatic wait_bits();
        for (int k = 0; k < 600 && mcnt < 18; k++) @(negedge clk);
        chk("bits_wait", 18, mcnt);
    endtask

    task automatic complete_run();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end

    initial begin
        repeat (12) @(negedge clk);
        rst_b <= 1'b1;
        repeat (2) @(negedge clk);
        t0 = cyc;
        convert();
        chk("busy_start", 1, busy);
        repeat (20) @(negedge clk);
        convert();
        wait_idle();
        chk("conv_len_ok", 1, (cyc - t0) inside {[120:130]});
        chk("oe_idle", 0, serial_result_oe);
        u_host_serial_model.shift(3, 1'b0, 1'b0);
        u_host_serial_model.shift(22, 1'b1, 1'b0);
        chk("slave_word", {10'h000, 18'h2D35A, 4'hF}, u_host_serial_model.got[21:0]);
        clock_source_sel <= 1'b0;
        conv_result <= 18'h1C3A5;
        u_host_serial_model.select(1'b1);
        chk("oe_on", 7, {sclk_oe, frame_sync_oe, serial_result_oe});
        mcnt = 0;
        convert();
        wait_idle();
        chk("m_bits", 18, mcnt);
        chk("m_word", 32'h1C3A5, {14'h0000, mword[17:0]});
        chk("busy_tail", 1, busy_at);
        chk("gap_fast", 4, gap);
        read_timing_cascade_in <= 1'b0;
        serial_clock_divider <= 1'b1;
        clock_invert <= 1'b1;
        conv_result <= 18'h0F0F3;
        repeat (3) @(negedge clk);
        chk("fs_idle_inv", 1, frame_sync);
        mcnt = 0;
        convert();
        wait_bits();
        chk("m_during", 32'h1C3A5, {14'h0000, mword[17:0]});
        chk("gap_slow", 16, gap);
        repeat (40) @(negedge clk);
        clock_invert <= 1'b0;
        serial_clock_divider <= 1'b0;
        read_timing_cascade_in <= 1'b1;
        iface_sel_lo <= 1'b0;
        mcnt = 0;
        convert();
        wait_idle();
        repeat (80) @(negedge clk);
        chk("no_serial", 0, mcnt);
        iface_sel_lo <= 1'b1;
        clock_source_sel <= 1'b1;
        read_timing_cascade_in <= 1'b0;
        u_host_serial_model.select(1'b0);
        convert();
        wait_idle();
        u_host_serial_model.shift(18, 1'b1, 1'b0);
        conv_result <= 18'h3A5C6;
        convert();
        wait_idle();
        e0 = nerr;
        u_host_serial_model.shift(10, 1'b1, 1'b1);
        conv_result <= 18'h05A3C;
        convert();
        u_host_serial_model.shift(8, 1'b1, 1'b0);
        wait_idle();
        chk("split_read", 32'h3A5C6, {14'h0000, u_host_serial_model.got[17:0]});
        chk("no_err", e0, nerr);
        convert();
        u_host_serial_model.shift(5, 1'b1, 1'b0);
        wait_idle();
        repeat (3) @(negedge clk);
        chk("err_pulse", e0 + 1, nerr);
        complete_run();
    end
endmodule
